// ### hdl/pfh_defs.vh
// Constants for the parallel flash host controller
`ifndef PFH_DEFS_VH
`define PFH_DEFS_VH

// Clock and bus timing
`define PFH_CLK_NS       50
`define PFH_WP_NS        100
`define PFH_RC_NS        100
`define PFH_WP_CYC       ((`PFH_WP_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_SYNC_CYC     2
`define PFH_RD_CYC       (((`PFH_RC_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS) + `PFH_SYNC_CYC)

// Widths
`define PFH_AW           19
`define PFH_CW           4

// User operation codes
`define PFH_OP_READ      3'h0
`define PFH_OP_PROG      3'h1
`define PFH_OP_SERASE    3'h2
`define PFH_OP_CERASE    3'h3
`define PFH_OP_IDENTRY   3'h4
`define PFH_OP_IDEXIT    3'h5
`define PFH_OP_HWID      3'h6

// Unlock and command codes
`define PFH_ADDR_CMD1    15'h5555
`define PFH_ADDR_CMD2    15'h2AAA
`define PFH_DAT_UNLK1    8'hAA
`define PFH_DAT_UNLK2    8'h55
`define PFH_DAT_PROG     8'hA0
`define PFH_DAT_ERASE    8'h80
`define PFH_DAT_SECT     8'h30
`define PFH_DAT_CHIP     8'h10
`define PFH_DAT_IDENTRY  8'h90
`define PFH_DAT_IDEXIT   8'hF0

// Sequence lengths in writes
`define PFH_LEN_PROG     3'h4
`define PFH_LEN_ERASE    3'h6
`define PFH_LEN_IDENTRY  3'h3
`define PFH_LEN_IDEXIT   3'h1

// Field positions
`define PFH_SECT_LSB     12
`define PFH_TOGGLE_BIT   6

`endif

// ### hdl/pfh_ctrl.v
// Host controller that drives an x8 parallel flash through its pins
//
// Behaviour
// RULE1: Device toggles bit six on successive reads while busy; host polls until stable.
// RULE2: Program status is valid after the fourth write pulse rises.
// RULE3: Erase status is valid after the sixth write pulse rises.
// RULE4: Write pulses shorter than the glitch threshold are ignored; host pulses are longer.
// RULE5: Device blocks writes at low supply; host has no control of that.
// RULE6: Host keeps output-enable high and chip-enable low while write-enable pulses.
// RULE7: Host precedes each byte program with the three-write unlock.
// RULE8: Host issues the full six-write sequence for every erase.
// RULE9: Unlock protection is always on; host sends the unlock prefix for every sequence except the single-write identification exit.
// RULE10: Invalid write mid-sequence aborts the device to read mode.
// RULE11: Identification entered by high voltage on pins or by command.
// RULE12: Identification reads: address zero maker code, address one device code.
// RULE13: Software identification mode holds until the exit sequence.
// RULE14: Device ignores identification exit while busy; host never issues it then.
// RULE15: Host drives data lines only while output-enable is high.
// RULE16: Sector erase takes the sector from top address bit down to bit twelve.
// RULE17: Device latches written byte; host releases data after write-enable rises.
// RULE18: Erase uses chip-enable low, output-enable high, write-enable low.
// RULE19: Hardware identification: read strobes, high voltage on id address pin, upper bits low.
// RULE20: Device is active only with chip-enable low; host idles it high.
// RULE21: Bit seven reads inverted data during program, zero during erase.
// RULE22: Sector erase sixth write is the sector code with the sector address.
// RULE23: Chip erase sixth write is the chip code at the command address.
// RULE24: Either exit form is accepted; host uses the single write form.
// RULE25: Program prefix is AA at 5555, 55 at 2AAA, A0 at 5555.
// RULE26: Writes during an internal operation are ignored; host only polls then.
`timescale 1ns/1ps
`include "pfh_defs.vh"

module pfh_ctrl (
	input  wire                clock,
	input  wire                srst,
	input  wire                cmd_valid,
	input  wire [2:0]          cmd_op,
	input  wire [`PFH_AW-1:0]  cmd_addr,
	input  wire [7:0]          cmd_data,
	output reg                 busy_r,
	output reg                 done_r,
	output reg  [7:0]          rd_data_r,
	output reg                 id_mode_r,
	output reg                 flash_ce_n_r,
	output reg                 flash_oe_n_r,
	output reg                 flash_we_n_r,
	output reg  [`PFH_AW-1:0]  flash_addr_r,
	output reg  [7:0]          data_lines_o_r,
	output reg                 data_lines_oe_r,
	input  wire [7:0]          data_lines_i,
	output reg                 id_high_voltage_r
);

	// One-hot states
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_WSET = 7'h02;
	localparam [6:0] ST_WLOW = 7'h04;
	localparam [6:0] ST_WREC = 7'h08;
	localparam [6:0] ST_RSET = 7'h10;
	localparam [6:0] ST_RPUL = 7'h20;
	localparam [6:0] ST_RCHK = 7'h40;

	// Counts are cut to the counter width on purpose
	localparam integer       WP_LAST_I = `PFH_WP_CYC - 1;
	localparam integer       RD_LAST_I = `PFH_RD_CYC - 1;
	localparam [`PFH_CW-1:0] WP_LAST   = WP_LAST_I[`PFH_CW-1:0];
	localparam [`PFH_CW-1:0] RD_LAST   = RD_LAST_I[`PFH_CW-1:0];

	reg [6:0]          state_r;
	reg [2:0]          op_r;
	reg [`PFH_AW-1:0]  addr_r;
	reg [7:0]          data_r;
	reg [2:0]          step_r;
	reg [`PFH_CW-1:0]  cnt_r;
	reg                poll_r;
	reg                have_prev_r;
	reg [7:0]          prev_r;
	reg [7:0]          dq_s1_r;
	reg [7:0]          dq_s2_r;

	// Number of bus writes each operation needs
	function [2:0] seq_len;
		input [2:0] op;
		begin
			case (op)
				`PFH_OP_PROG:    seq_len = `PFH_LEN_PROG;
				`PFH_OP_SERASE:  seq_len = `PFH_LEN_ERASE;
				`PFH_OP_CERASE:  seq_len = `PFH_LEN_ERASE;
				`PFH_OP_IDENTRY: seq_len = `PFH_LEN_IDENTRY;
				default:         seq_len = `PFH_LEN_IDEXIT;
			endcase
		end
	endfunction

	// Address and data of one write of a sequence, upper command address bits held low
	function [`PFH_AW+7:0] seq_word;
		input [2:0]         op;
		input [2:0]         step;
		input [`PFH_AW-1:0] uaddr;
		input [7:0]         udata;
		reg   [`PFH_AW-1:0] a;
		reg   [7:0]         d;
		begin
			a = {{(`PFH_AW-15){1'b0}}, `PFH_ADDR_CMD1};
			d = `PFH_DAT_UNLK1;                                // RULE9
			if (op == `PFH_OP_IDEXIT)
			begin
				a = {`PFH_AW{1'b0}};
				d = `PFH_DAT_IDEXIT;                           // RULE24
			end
			else if (step == 3'h1 || step == 3'h4)
			begin
				a = {{(`PFH_AW-15){1'b0}}, `PFH_ADDR_CMD2};
				d = `PFH_DAT_UNLK2;                            // RULE25
			end
			else if (step == 3'h2)
			begin
				if (op == `PFH_OP_PROG)
					d = `PFH_DAT_PROG;                         // RULE7
				else if (op == `PFH_OP_IDENTRY)
					d = `PFH_DAT_IDENTRY;                      // RULE11
				else
					d = `PFH_DAT_ERASE;                        // RULE8
			end
			else if (step == 3'h3 && op == `PFH_OP_PROG)
			begin
				a = uaddr;
				d = udata;
			end
			else if (step == 3'h5 && op == `PFH_OP_SERASE)
			begin
				a = {uaddr[`PFH_AW-1:`PFH_SECT_LSB], {`PFH_SECT_LSB{1'b0}}}; // RULE16
				d = `PFH_DAT_SECT;                             // RULE22
			end
			else if (step == 3'h5)
				d = `PFH_DAT_CHIP;                             // RULE23
			seq_word = {a, d};
		end
	endfunction

	// Data lines come from the pins, so they pass two flops first
	always @(posedge clock)
	begin
		dq_s1_r <= data_lines_i;
		dq_s2_r <= dq_s1_r;
	end

	// Bus sequencer
	always @(posedge clock)
	begin
		if (srst)
		begin
			state_r           <= ST_IDLE;
			op_r              <= `PFH_OP_READ;
			addr_r            <= {`PFH_AW{1'b0}};
			data_r            <= 8'h00;
			step_r            <= 3'h0;
			cnt_r             <= {`PFH_CW{1'b0}};
			poll_r            <= 1'b0;
			have_prev_r       <= 1'b0;
			prev_r            <= 8'h00;
			busy_r            <= 1'b0;
			done_r            <= 1'b0;
			rd_data_r         <= 8'h00;
			id_mode_r         <= 1'b0;
			flash_ce_n_r      <= 1'b1;
			flash_oe_n_r      <= 1'b1;
			flash_we_n_r      <= 1'b1;                     // RULE5
			flash_addr_r      <= {`PFH_AW{1'b0}};
			data_lines_o_r    <= 8'h00;
			data_lines_oe_r   <= 1'b0;
			id_high_voltage_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					flash_ce_n_r <= 1'b1;                      // RULE20
					if (cmd_valid)                             // RULE14 RULE26
					begin
						busy_r      <= 1'b1;
						op_r        <= cmd_op;
						addr_r      <= cmd_addr;
						data_r      <= cmd_data;
						step_r      <= 3'h0;                   // RULE10
						poll_r      <= 1'b0;
						have_prev_r <= 1'b0;
						if (cmd_op == `PFH_OP_HWID)
						begin
							id_high_voltage_r <= 1'b1;          // RULE19
							flash_addr_r      <= {{(`PFH_AW-1){1'b0}}, cmd_addr[0]}; // RULE12
							state_r           <= ST_RSET;
						end
						else if (cmd_op == `PFH_OP_READ)
						begin
							flash_addr_r <= cmd_addr;
							state_r      <= ST_RSET;
						end
						else
							state_r <= ST_WSET;
					end
				end
				ST_WSET:
				begin
					// Output-enable stays high across the write, so the bus never fights
					{flash_addr_r, data_lines_o_r} <= seq_word(op_r, step_r, addr_r, data_r);
					flash_oe_n_r    <= 1'b1;                   // RULE6
					data_lines_oe_r <= 1'b1;                   // RULE15
					flash_ce_n_r    <= 1'b0;                   // RULE18
					flash_we_n_r    <= 1'b0;
					cnt_r           <= WP_LAST;
					state_r         <= ST_WLOW;
				end
				ST_WLOW:
				begin
					// Pulse spans whole clock periods, well over the glitch threshold
					if (cnt_r == {`PFH_CW{1'b0}})
					begin
						flash_we_n_r <= 1'b1;                  // RULE4
						state_r      <= ST_WREC;
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
				ST_WREC:
				begin
					// Data is latched by the rising edge, so it may be released now
					flash_ce_n_r    <= 1'b1;
					data_lines_oe_r <= 1'b0;                   // RULE17
					step_r          <= step_r + 1'b1;
					if (step_r == seq_len(op_r) - 1'b1)
					begin
						if (op_r == `PFH_OP_PROG || op_r == `PFH_OP_SERASE || op_r == `PFH_OP_CERASE)
						begin
							// Status is polled only after the final write pulse
							poll_r  <= 1'b1;                   // RULE2 RULE3 RULE26
							state_r <= ST_RSET;
						end
						else
						begin
							id_mode_r <= (op_r == `PFH_OP_IDENTRY); // RULE13
							busy_r    <= 1'b0;
							done_r    <= 1'b1;
							state_r   <= ST_IDLE;
						end
					end
					else
						state_r <= ST_WSET;
				end
				ST_RSET:
				begin
					data_lines_oe_r <= 1'b0;                   // RULE15
					flash_ce_n_r    <= 1'b0;
					flash_oe_n_r    <= 1'b0;
					cnt_r           <= RD_LAST;
					state_r         <= ST_RPUL;
				end
				ST_RPUL:
				begin
					// Strobe covers the read cycle time plus the two sync stages
					if (cnt_r == {`PFH_CW{1'b0}})
					begin
						rd_data_r    <= dq_s2_r;
						flash_ce_n_r <= 1'b1;
						flash_oe_n_r <= 1'b1;
						state_r      <= ST_RCHK;
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
				ST_RCHK:
				begin
					if (poll_r && !(have_prev_r &&
						prev_r[`PFH_TOGGLE_BIT] == rd_data_r[`PFH_TOGGLE_BIT]))
					begin
						// Toggling still; no timeout, a dead part keeps busy high
						prev_r      <= rd_data_r;              // RULE1 RULE21
						have_prev_r <= 1'b1;
						state_r     <= ST_RSET;
					end
					else
					begin
						id_high_voltage_r <= 1'b0;
						busy_r            <= 1'b0;
						done_r            <= 1'b1;
						state_r           <= ST_IDLE;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

endmodule // pfh_ctrl

// ### tb/pfh_monitor.sv
// Pin-level checker for the flash host controller
`timescale 1ns/1ps
`include "pfh_defs.vh"
module pfh_monitor (
	input wire               clock,
	input wire               srst,
	input wire               cmd_valid,
	input wire [2:0]         cmd_op,
	input wire               busy_r,
	input wire               done_r,
	input wire               flash_ce_n_r,
	input wire               flash_oe_n_r,
	input wire               flash_we_n_r,
	input wire [`PFH_AW-1:0] flash_addr_r,
	input wire [7:0]         data_lines_o_r,
	input wire               data_lines_oe_r,
	input wire               id_high_voltage_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Two low cycles of write strobe, then release
	sequence s_wr_pulse;
		!flash_we_n_r ##1 !flash_we_n_r ##1 flash_we_n_r;
	endsequence
	// Read walk: busy, then a done pulse inside the read slot
	sequence s_rd_done;
		busy_r ##[5:7] done_r;
	endsequence
	we_mode_a: assert property (!flash_we_n_r |-> !flash_ce_n_r && flash_oe_n_r)
		else $error("write strobe outside write mode");
	drive_gate_a: assert property (data_lines_oe_r |-> flash_oe_n_r)
		else $error("data driven while output enable low");
	done_pulse_a: assert property (done_r |=> !done_r)
		else $error("done longer than one cycle");
	we_width_a: assert property ($fell(flash_we_n_r) |-> s_wr_pulse)
		else $error("write strobe width wrong");
	wr_hold_a: assert property (!flash_we_n_r && !$past(flash_we_n_r) |->
		data_lines_oe_r && $stable(data_lines_o_r) && $stable(flash_addr_r))
		else $error("write data or address moved");
	release_a: assert property ($rose(flash_we_n_r) |-> data_lines_oe_r ##1 !data_lines_oe_r)
		else $error("data release out of place");
	hv_addr_a: assert property (id_high_voltage_r && !flash_oe_n_r |->
		flash_we_n_r && flash_addr_r[`PFH_AW-1:1] == 0)
		else $error("hardware id read malformed");
	rd_done_a: assert property (cmd_valid && !busy_r && cmd_op == `PFH_OP_READ |=> s_rd_done)
		else $error("read did not finish in time");
endmodule // pfh_monitor

bind pfh_ctrl pfh_monitor pfh_monitor_inst (.clock, .srst, .cmd_valid, .cmd_op, .busy_r, .done_r, .flash_ce_n_r,
	.flash_oe_n_r, .flash_we_n_r, .flash_addr_r, .data_lines_o_r, .data_lines_oe_r, .id_high_voltage_r);

// ### tb/pfh_flash_model.sv
// Behavioural x8 flash device facing the host controller
`timescale 1ns/1ps
module pfh_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'hA5  // Arbitrary value
) (
	input  logic        ce_n,
	input  logic        oe_n,
	input  logic        we_n,
	input  logic        hv,
	input  logic [18:0] addr,
	input  logic [7:0]  dq_i,
	input  int          busy_len,
	output logic [7:0]  dq_o,
	output logic        dq_oe
);
	logic [7:0] mem [0:524287];
	logic [7:0] dq_v = 8'h00;
	logic [7:0] last = 8'h00;
	int         step = 0;
	int         left = 0;
	bit         sw_id, tog, ers;
	time        t_fall = 0;
	localparam bit VDD_OK = 1'b1; // Supply never sags in this model
	// Start of an internal operation; busy length counted in reads
	task automatic begin_op(input logic [7:0] d, input bit e);
		last = d;
		ers = e;
		left = busy_len;
		step = 0;
	endtask
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// Falling strobe time kept for the glitch filter
	always @(negedge we_n) t_fall = $time;
	// Command decoder; byte latched at the rising strobe
	always @(posedge we_n)
	begin
		if (ce_n || !oe_n || !VDD_OK || $time - t_fall < 5)
			;
		else if (left > 0)
			;
		else if (step == 0 && dq_i == 8'hF0)
			sw_id = 0;
		else if (step == 0 || step == 4)
			step = (addr[14:0] == 15'h5555 && dq_i == 8'hAA) ? step + 1 : 0;
		else if (step == 1 || step == 5)
			step = (addr[14:0] == 15'h2AAA && dq_i == 8'h55) ? step + 1 : 0;
		else if (step == 2)
		begin
			if (addr[14:0] == 15'h5555 && dq_i inside {8'h90, 8'hF0})
				sw_id = dq_i == 8'h90;
			step = (addr[14:0] != 15'h5555) ? 0 : (dq_i == 8'hA0) ? 3 : (dq_i == 8'h80) ? 4 : 0;
		end
		else if (step == 3)
		begin
			mem[addr] = dq_i;
			begin_op(dq_i, 0);
		end
		else if (dq_i == 8'h30)
		begin
			for (int i = 0; i < 4096; i++) mem[{addr[18:12], i[11:0]}] = 8'hFF;
			begin_op(8'hFF, 1);
		end
		else if (dq_i == 8'h10 && addr[14:0] == 15'h5555)
		begin
			foreach (mem[i]) mem[i] = 8'hFF;
			begin_op(8'hFF, 1);
		end
		else
			step = 0;
	end
	// Read: status while busy, codes in id mode, array otherwise
	always @(negedge oe_n)
	begin
		#1;
		if (ce_n || oe_n)
			;
		else if (left > 0)
		begin
			tog = !tog;
			left--;
			dq_v = {ers ? 1'b0 : ~last[7], tog, last[5:0]};
		end
		else if (sw_id || hv)
			dq_v = addr[0] ? DEV_CODE : MAKER_CODE;
		else
			dq_v = mem[addr];
	end
	assign dq_oe = !ce_n && !oe_n;
	assign dq_o = dq_oe ? dq_v : ~dq_v; // Released lines never repeat the old byte
endmodule // pfh_flash_model

// ### tb/tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "pfh_defs.vh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
	$display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
	localparam logic [7:0] DEV   = 8'hA5; // Arbitrary value
	logic               clock = 1'b0;
	logic               srst = 1'b1;
	logic               cmd_valid = 1'b0;
	logic [2:0]         cmd_op = 3'h0;
	logic [`PFH_AW-1:0] cmd_addr = 19'h00000;
	logic [7:0]         cmd_data = 8'h00;
	wire                busy_r, done_r, id_mode_r, c_n, o_n, w_n, dhe, dfe, hv;
	wire  [7:0]         rd_data_r, dh, df, dw;
	wire  [`PFH_AW-1:0] fa;
	int                 busy_len = 0;
	int                 err_total = 0;
	int                 comparisons = 0;
	int                 cycles = 0;
	logic [`PFH_AW-1:0] a;
	logic [7:0]         d;
	// Clock at 20 MHz
	always #25 clock = ~clock;
	// Shared data wire selected by the host enable alone
	assign dw = dhe ? dh : df;
	pfh_ctrl pfh_ctrl_inst (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy_r(busy_r), .done_r(done_r), .rd_data_r(rd_data_r),
		.id_mode_r(id_mode_r), .flash_ce_n_r(c_n), .flash_oe_n_r(o_n), .flash_we_n_r(w_n),
		.flash_addr_r(fa), .data_lines_o_r(dh), .data_lines_oe_r(dhe), .data_lines_i(dw),
		.id_high_voltage_r(hv));
	pfh_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) pfh_flash_model_inst (.ce_n(c_n), .oe_n(o_n),
		.we_n(w_n), .hv(hv), .addr(fa), .dq_i(dw), .busy_len(busy_len), .dq_o(df), .dq_oe(dfe));
	// One request, then wait for its done pulse under a bound
	task automatic op(input logic [2:0] o, input logic [`PFH_AW-1:0] x, input logic [7:0] v);
		int n;
		n = 0;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_op <= o;
		cmd_addr <= x;
		cmd_data <= v;
		@(posedge clock);
		cmd_valid <= 1'b0;
		do @(negedge clock); while (done_r !== 1'b1 && ++n < 2000);
		if (done_r !== 1'b1)
		begin
			err_total++;
			$display("Error %0t: no done pulse", $time);
			complete_run();
		end
	endtask
	// Array read compared with an expected byte
	task automatic rd(input logic [`PFH_AW-1:0] x, input logic [7:0] e);
		op(`PFH_OP_READ, x, 8'h00);
		`CHK(rd_data_r, e)
	endtask
	// Expected identification byte for an address
	function automatic logic [7:0] id_code(input int i);
		return i[0] ? DEV : MAKER;
	endfunction
	// Verdict and end of run
	task automatic complete_run();
		$display("Errors %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Cycle ceiling against a hang
	always @(posedge clock)
	begin
		cycles++;
		// Host and flash must never drive the data wire together
		if (!srst && dhe === 1'b1)
			`CHK(dfe, 1'b0)
		if (cycles == 40000)
		begin
			err_total++;
			complete_run();
		end
	end
	// Main sequence
	initial
	begin
		void'($urandom(93763));
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			a = (i == 0) ? 19'h7FFFF : 19'($urandom);
			d = $urandom;
			busy_len = $urandom_range(5);
			op(`PFH_OP_PROG, a, d);
			`CHK(rd_data_r, d)
			rd(a, d);
		end
		op(`PFH_OP_PROG, 19'h01FFF, 8'h5A);
		op(`PFH_OP_PROG, 19'h02000, 8'hC3);
		busy_len = 3;
		op(`PFH_OP_SERASE, 19'h02ABC, 8'h00);
		`CHK(rd_data_r, 8'hFF)
		rd(19'h02000, 8'hFF);
		rd(19'h01FFF, 8'h5A);
		op(`PFH_OP_CERASE, 19'h00000, 8'h00);
		rd(19'h01FFF, 8'hFF);
		op(`PFH_OP_IDENTRY, 19'h00000, 8'h00);
		`CHK(id_mode_r, 1'b1)
		for (int i = 0; i < 2; i++) rd(i, id_code(i));
		op(`PFH_OP_IDEXIT, 19'h00000, 8'h00);
		`CHK(id_mode_r, 1'b0)
		rd(19'h00001, 8'hFF);
		for (int i = 0; i < 2; i++)
		begin
			op(`PFH_OP_HWID, i, 8'h00);
			`CHK(rd_data_r, id_code(i))
		end
		complete_run();
	end
endmodule // tb
